// [puel_pkg.sv]
// Purpose: constants for the uncorrectable error log register bank
// Assumes: byte addresses in extended config space, dword accesses
// Notes:   reserved bits read as zero through the implemented mask
package puel_pkg;

  // register offsets, bytes
  localparam logic [11:0] CAP_HDR_OFF      = 12'h100;
  localparam logic [11:0] NEXT_CAP_OFF     = 12'h102;
  localparam logic [11:0] FLAGS_OFF        = 12'h104;
  localparam logic [11:0] SUPPRESS_OFF     = 12'h108;

  // capability header content
  localparam logic [15:0] CAP_ID           = 16'h0001;
  localparam logic [3:0]  CAP_VERSION      = 4'h1;
  localparam logic [11:0] NEXT_PTR_END     = 12'h000;
  localparam logic [11:0] NEXT_PTR_VC      = 12'h150;

  // error bit positions in flags and suppress registers
  localparam int unsigned UR_BIT           = 20;
  localparam int unsigned ECRC_BIT         = 19;
  localparam int unsigned MALF_BIT         = 18;
  localparam int unsigned OVFL_BIT         = 17;
  localparam int unsigned UNXP_BIT         = 16;
  localparam int unsigned CABT_BIT         = 15;
  localparam int unsigned CTMO_BIT         = 14;
  localparam int unsigned FCPE_BIT         = 13;
  localparam int unsigned PSN_BIT          = 12;
  localparam int unsigned DLLP_BIT         = 4;

  // implemented bits; everything else is reserved
  localparam logic [31:0] IMPL_BITS        = 32'h001f_f010;

  // values after reset
  localparam logic [31:0] FLAGS_RST        = 32'h0000_0000;
  localparam logic [31:0] SUPPRESS_RST     = 32'h0000_0000;
  localparam logic [31:0] RDATA_RST        = 32'h0000_0000;
  localparam logic [4:0]  FEP_RST          = 5'h00;

endpackage : puel_pkg

// [puel_sync.sv]
// Purpose: two-flop synchroniser for asynchronous pin levels
// Assumes: synchronous active-high reset on the destination clock
// Notes:   resets to the idle level given by RST_VAL
module puel_sync #(
  parameter int unsigned W       = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         reset,
  // level in and out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_sync_out;

  always_comb begin
    next_stage1   = async_in;
    next_sync_out = stage1;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stage1   <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      stage1   <= next_stage1;
      sync_out <= next_sync_out;
    end
  end

endmodule : puel_sync

// [puel_top.sv]
// Purpose: uncorrectable error log: capability header, flags, suppress
// Assumes: config access port on ref_clk; detector pulses on ref_clk
// Notes:   flags and suppress survive hot reset, cleared by link resets
// Behaviour
// - next pointer upper twelve bits read 000h, or 150h with vc enable
// - low four bits of next pointer register read fixed version 1h
// - writing one clears a status flag; writing zero leaves it alone
// - unsupported request received sets status bit 20
// - end-to-end crc mismatch sets status bit 19
// - malformed packet detected sets status bit 18
// - sender exceeding granted credits sets status bit 17
// - completion matching no outstanding request sets status bit 16
// - request ended with completer abort sets status bit 15
// - request without completion before timeout sets status bit 14
// - flow control protocol violation, any phase, sets status bit 13
// - poisoned packet received sets status bit 12
// - data link layer protocol violation sets status bit 4
// - reserved ranges 31:21, 11:5, 3:0 read zero in status and mask
// - masked error sets no flag, message, header log or pointer
// - each flag has a read/write mask bit, reset 0, 1 means masked
// - flags and masks reset by link, global or power-on reset only
module puel_top (
  // clock and power-on reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // reset pins, asynchronous, active low
  input  wire logic        fundamental_link_reset_n,
  input  wire logic        global_reset_n,
  // general control
  input  wire logic        virtual_channel_struct_enable,
  // configuration access
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [11:0] cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  output logic             cfg_rd_valid,
  // error detectors, one-cycle pulses
  input  wire logic        unsupported_request_det,
  input  wire logic        end_to_end_crc_det,
  input  wire logic        malformed_packet_det,
  input  wire logic        receiver_overflow_det,
  input  wire logic        unexpected_completion_det,
  input  wire logic        completer_abort_det,
  input  wire logic        completion_timeout_det,
  input  wire logic        flow_credit_protocol_det,
  input  wire logic        poisoned_packet_det,
  input  wire logic        link_protocol_det,
  // reporting to message, header log and pointer logic
  output logic             err_msg_req,
  output logic             hdr_log_load,
  output logic      [4:0]  first_err_ptr
);

  function automatic logic [31:0] lanes(input logic [3:0] be);
    lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : lanes

  function automatic logic [4:0] lowest(input logic [31:0] v);
    lowest = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        lowest = 5'(i);
      end
    end
  endfunction : lowest

  // link reset pins cross into ref_clk
  logic [1:0] rst_pins_s;

  puel_sync #(
    .W       (2),
    .RST_VAL (2'h3)
  ) puel_sync_i (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .async_in ({fundamental_link_reset_n, global_reset_n}),
    .sync_out (rst_pins_s)
  );

  // sticky bits ignore hot reset; only these sources clear them
  logic sticky_clr;
  assign sticky_clr = reset | ~rst_pins_s[1] | ~rst_pins_s[0];

  // state
  logic [31:0] flags;
  logic [31:0] suppress;
  logic [31:0] next_flags;
  logic [31:0] next_suppress;
  logic [31:0] next_cfg_rdata;
  logic        next_cfg_rd_valid;
  logic        next_err_msg_req;
  logic        next_hdr_log_load;
  logic [4:0]  next_first_err_ptr;

  // decode
  logic        hit_hdr;
  logic        hit_flags;
  logic        hit_supp;
  logic [31:0] wr_bits;
  logic [31:0] det_vec;
  logic [31:0] live_err;
  logic [11:0] next_ptr;

  localparam logic [9:0] CAP_HDR_OFF_W = puel_pkg::CAP_HDR_OFF[11:2];

  always_comb begin
    hit_hdr   = cfg_addr[11:2] == CAP_HDR_OFF_W;
    hit_flags = cfg_addr[11:2] == puel_pkg::FLAGS_OFF[11:2];
    hit_supp  = cfg_addr[11:2] == puel_pkg::SUPPRESS_OFF[11:2];
    wr_bits   = cfg_wdata & lanes(cfg_be) & puel_pkg::IMPL_BITS;
    det_vec   = 32'h0000_0000;
    det_vec[puel_pkg::UR_BIT]   = unsupported_request_det;
    det_vec[puel_pkg::ECRC_BIT] = end_to_end_crc_det;
    det_vec[puel_pkg::MALF_BIT] = malformed_packet_det;
    det_vec[puel_pkg::OVFL_BIT] = receiver_overflow_det;
    det_vec[puel_pkg::UNXP_BIT] = unexpected_completion_det;
    det_vec[puel_pkg::CABT_BIT] = completer_abort_det;
    det_vec[puel_pkg::CTMO_BIT] = completion_timeout_det;
    det_vec[puel_pkg::FCPE_BIT] = flow_credit_protocol_det;
    det_vec[puel_pkg::PSN_BIT]  = poisoned_packet_det;
    det_vec[puel_pkg::DLLP_BIT] = link_protocol_det;
    // masked errors vanish here, before any reporting path
    live_err  = det_vec & ~suppress & puel_pkg::IMPL_BITS;
    next_ptr  = virtual_channel_struct_enable ? puel_pkg::NEXT_PTR_VC
                                              : puel_pkg::NEXT_PTR_END;
  end

  // sticky flag and suppress registers
  always_comb begin
    next_flags    = flags;
    next_suppress = suppress;
    if (cfg_wr && hit_flags) begin
      next_flags = flags & ~wr_bits;
    end
    if (cfg_wr && hit_supp) begin
      next_suppress = (suppress & ~(lanes(cfg_be) & puel_pkg::IMPL_BITS))
                    | wr_bits;
    end
    // set after clear so a same-cycle detection wins
    next_flags = next_flags | live_err;
    next_flags = next_flags & puel_pkg::IMPL_BITS;
  end

  always_ff @(posedge ref_clk) begin
    if (sticky_clr) begin
      flags    <= puel_pkg::FLAGS_RST;
      suppress <= puel_pkg::SUPPRESS_RST;
    end else begin
      flags    <= next_flags;
      suppress <= next_suppress;
    end
  end

  // reporting; the pointer only moves when no unmasked flag is pending
  always_comb begin
    next_err_msg_req   = |live_err;
    next_hdr_log_load  = 1'b0;
    next_first_err_ptr = first_err_ptr;
    if ((|live_err) && (flags & ~suppress) == 32'h0000_0000) begin
      next_hdr_log_load  = 1'b1;
      next_first_err_ptr = lowest(live_err);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sticky_clr) begin
      err_msg_req   <= 1'b0;
      hdr_log_load  <= 1'b0;
      first_err_ptr <= puel_pkg::FEP_RST;
    end else begin
      err_msg_req   <= next_err_msg_req;
      hdr_log_load  <= next_hdr_log_load;
      first_err_ptr <= next_first_err_ptr;
    end
  end

  // read path, one cycle latency; unmapped dwords read zero
  always_comb begin
    next_cfg_rd_valid = cfg_rd;
    next_cfg_rdata    = puel_pkg::RDATA_RST;
    if (cfg_rd) begin
      if (hit_hdr) begin
        next_cfg_rdata = {next_ptr, puel_pkg::CAP_VERSION,
                          puel_pkg::CAP_ID};
      end else if (hit_flags) begin
        next_cfg_rdata = flags & puel_pkg::IMPL_BITS;
      end else if (hit_supp) begin
        next_cfg_rdata = suppress & puel_pkg::IMPL_BITS;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cfg_rdata    <= puel_pkg::RDATA_RST;
      cfg_rd_valid <= 1'b0;
    end else begin
      cfg_rdata    <= next_cfg_rdata;
      cfg_rd_valid <= next_cfg_rd_valid;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sticky_clr);

  logic rd_hdr;
  assign rd_hdr = cfg_rd && hit_hdr;

  ptr_end_a: assert property (
    rd_hdr && !virtual_channel_struct_enable |=> cfg_rdata[31:20] == 12'h000)
    else $error("next pointer not end of list");
  ptr_vc_a: assert property (
    rd_hdr && virtual_channel_struct_enable |=> cfg_rdata[31:20] == 12'h150)
    else $error("next pointer not vc structure");
  cap_version_a: assert property (
    rd_hdr |=> cfg_rdata[19:16] == 4'h1 && cfg_rd_valid)
    else $error("capability version wrong");
  flag_clear_a: assert property (
    cfg_wr && hit_flags && cfg_be == 4'hf
    && (det_vec & cfg_wdata) == 32'h0000_0000
    |=> (flags & $past(cfg_wdata)) == 32'h0000_0000)
    else $error("write one did not clear flag");
  zero_keeps_a: assert property (
    1'b1 |=> ($past(flags) & ~flags & ~$past(wr_bits & {32{cfg_wr
      && hit_flags}})) == 32'h0000_0000)
    else $error("flag lost without write one");
  ur_set_a: assert property (
    unsupported_request_det && !suppress[20] |=> flags[20])
    else $error("unsupported request flag not set");
  ecrc_set_a: assert property (
    end_to_end_crc_det && !suppress[19] |=> flags[19])
    else $error("end-to-end crc flag not set");
  malf_set_a: assert property (
    malformed_packet_det && !suppress[18] |=> flags[18])
    else $error("malformed packet flag not set");
  ovfl_set_a: assert property (
    receiver_overflow_det && !suppress[17] |=> flags[17])
    else $error("receiver overflow flag not set");
  unxp_set_a: assert property (
    unexpected_completion_det && !suppress[16] |=> flags[16])
    else $error("unexpected completion flag not set");
  cabt_set_a: assert property (
    completer_abort_det && !suppress[15] |=> flags[15])
    else $error("completer abort flag not set");
  ctmo_set_a: assert property (
    completion_timeout_det && !suppress[14] |=> flags[14])
    else $error("completion timeout flag not set");
  fcpe_set_a: assert property (
    flow_credit_protocol_det && !suppress[13] |=> flags[13])
    else $error("flow control flag not set");
  psn_set_a: assert property (
    poisoned_packet_det && !suppress[12] |=> flags[12])
    else $error("poisoned packet flag not set");
  dllp_set_a: assert property (
    link_protocol_det && !suppress[4] |=> flags[4])
    else $error("link protocol flag not set");
  reserved_zero_a: assert property (
    cfg_rd && (hit_flags || hit_supp)
    |=> (cfg_rdata & 32'hffe0_0fef) == 32'h0000_0000)
    else $error("reserved bits read nonzero");
  masked_quiet_a: assert property (
    1'b1 |=> (flags & ~$past(flags) & $past(suppress)) == 32'h0000_0000
      && (!err_msg_req || ($past(det_vec) & ~$past(suppress))
        != 32'h0000_0000))
    else $error("masked error was reported");
  mask_write_a: assert property (
    cfg_wr && hit_supp && cfg_be == 4'hf
    |=> suppress == ($past(cfg_wdata) & 32'h001f_f010))
    else $error("mask register write lost");
  sticky_reset_a: assert property (
    @(posedge ref_clk) disable iff (1'b0)
    sticky_clr |=> flags == 32'h0000_0000 && suppress == 32'h0000_0000)
    else $error("sticky bits not cleared by link reset");
  set_wins_a: assert property (
    cfg_wr && hit_flags && (wr_bits & live_err) != 0
    |=> (flags & $past(wr_bits & live_err)) == $past(wr_bits & live_err))
    else $error("clear beat same-cycle detection");

  vc_read_c: cover property (rd_hdr && virtual_channel_struct_enable);
  clear_c: cover property (cfg_wr && hit_flags && (flags & wr_bits) != 0);
  masked_c: cover property ((det_vec & suppress) != 0);
  race_c: cover property (cfg_wr && hit_flags && (wr_bits & live_err) != 0);

endmodule : puel_top

// [puel_partner.sv]
// Purpose: far-side event source driving the error detector pulses
// Assumes: bench gives a one-cycle event vector in flag positions
// Notes:   no delay added; masking is the block's job, not ours
module puel_partner (
  // event vector from the bench
  input  wire logic [31:0] ev,
  // detector pulses toward the block
  output logic             unsupported_request_det,
  output logic             end_to_end_crc_det,
  output logic             malformed_packet_det,
  output logic             receiver_overflow_det,
  output logic             unexpected_completion_det,
  output logic             completer_abort_det,
  output logic             completion_timeout_det,
  output logic             flow_credit_protocol_det,
  output logic             poisoned_packet_det,
  output logic             link_protocol_det
);
  timeunit 1ns;
  timeprecision 1ps;

  assign unsupported_request_det   = ev[20];
  assign end_to_end_crc_det        = ev[19];
  assign malformed_packet_det      = ev[18];
  assign receiver_overflow_det     = ev[17];
  assign unexpected_completion_det = ev[16];
  assign completer_abort_det       = ev[15];
  assign completion_timeout_det    = ev[14];
  assign flow_credit_protocol_det  = ev[13];
  assign poisoned_packet_det       = ev[12];
  assign link_protocol_det         = ev[4];
endmodule : puel_partner

// [puel_top_tb.sv]
// Purpose: self-checking bench for the uncorrectable error log
// Assumes: inputs change at falling edges; reads scored from a queue
// Notes:   flag model kept here; events and clears share cycles often
module puel_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'h0, reset = 1'h1, vc_en = 1'h0;
  logic        link_n = 1'h1, glob_n = 1'h1, cfg_wr = 1'h0, cfg_rd = 1'h0;
  logic [11:0] cfg_addr = 12'h000;
  logic [3:0]  cfg_be = 4'hf;
  logic [31:0] cfg_wdata = 32'h0, ev = 32'h0, cfg_rdata, r;
  logic [31:0] flags_m = 32'h0, mask_m = 32'h0, rng = 32'h5e;
  logic        cfg_rd_valid, err_msg_req, hdr_log_load;
  logic [4:0]  first_err_ptr;
  logic [31:0] exp_q[$];
  logic unsupported_request_det, end_to_end_crc_det, malformed_packet_det;
  logic receiver_overflow_det, unexpected_completion_det;
  logic completer_abort_det, completion_timeout_det;
  logic flow_credit_protocol_det, poisoned_packet_det, link_protocol_det;
  int          err_total = 0, checks_done = 0, cyc = 0;
  int          bits[10] = '{20, 19, 18, 17, 16, 15, 14, 13, 12, 4};
  localparam logic [31:0] IMPL = 32'h001f_f010;

  always #2.5 ref_clk = ~ref_clk;

  puel_partner puel_partner_i (.ev, .unsupported_request_det,
    .end_to_end_crc_det, .malformed_packet_det, .receiver_overflow_det,
    .unexpected_completion_det, .completer_abort_det,
    .completion_timeout_det, .flow_credit_protocol_det,
    .poisoned_packet_det, .link_protocol_det);
  puel_top puel_top_i (.ref_clk, .reset, .fundamental_link_reset_n(link_n),
    .global_reset_n(glob_n), .virtual_channel_struct_enable(vc_en),
    .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata,
    .cfg_rd_valid, .unsupported_request_det, .end_to_end_crc_det,
    .malformed_packet_det, .receiver_overflow_det,
    .unexpected_completion_det, .completer_abort_det,
    .completion_timeout_det, .flow_credit_protocol_det,
    .poisoned_packet_det, .link_protocol_det, .err_msg_req,
    .hdr_log_load, .first_err_ptr);

  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : xs

  task automatic chk(input logic [31:0] seen, want, input string what);
    checks_done++;
    if (seen !== want) begin
      err_total++;
      $display("[FAIL] %0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim

  // wr, rd and step each return two falling edges later so no strobe is set twice at once
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr = 1'h1;
    @(negedge ref_clk);
    cfg_wr = 1'h0;
    @(negedge ref_clk);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] want);
    cfg_addr = a;
    cfg_rd = 1'h1;
    exp_q.push_back(want);
    @(negedge ref_clk);
    cfg_rd = 1'h0;
    @(negedge ref_clk);
  endtask : rd

  // event and write-one clear launched on the same edge
  task automatic step(input logic [31:0] e, clr);
    logic [31:0] hit;
    logic        first;
    int          low;
    hit = e & ~mask_m & IMPL;
    first = (hit != 0) && ((flags_m & ~mask_m) == 0);
    low = 0;
    for (int i = 31; i >= 0; i--) if (hit[i]) low = i;
    ev = e;
    cfg_addr = puel_pkg::FLAGS_OFF;
    cfg_wdata = clr;
    cfg_wr = 1'h1;
    @(negedge ref_clk);
    ev = 32'h0;
    cfg_wr = 1'h0;
    chk({31'h0, err_msg_req}, {31'h0, hit != 0}, "message");
    chk({31'h0, hdr_log_load}, {31'h0, first}, "header load");
    if (first) chk({27'h0, first_err_ptr}, low, "pointer");
    flags_m = (flags_m & ~clr) | hit;
    @(negedge ref_clk);
  endtask : step

  task automatic pin_reset(input bit glob);
    step(IMPL, 32'h0);
    link_n = glob;
    glob_n = !glob;
    repeat (4) @(negedge ref_clk);
    rd(puel_pkg::FLAGS_OFF, 32'h0);
    link_n = 1'h1;
    glob_n = 1'h1;
    repeat (3) @(negedge ref_clk);
    flags_m = 32'h0;
    mask_m = 32'h0;
    rd(puel_pkg::SUPPRESS_OFF, 32'h0);
  endtask : pin_reset

  always @(negedge ref_clk) begin
    if (cfg_rd_valid === 1'h1) begin
      if (exp_q.size() == 0) chk(cfg_rdata, 32'hdead, "stray answer");
      else chk(cfg_rdata, exp_q.pop_front(), "read data");
    end
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      end_sim();
    end
  end

  initial begin
    repeat (8) @(negedge ref_clk);
    reset = 1'h0;
    wr(puel_pkg::CAP_HDR_OFF, 32'hffff_ffff);
    rd(puel_pkg::CAP_HDR_OFF, 32'h0001_0001);
    vc_en = 1'h1;
    rd(puel_pkg::NEXT_CAP_OFF, 32'h1501_0001);
    rd(puel_pkg::FLAGS_OFF, 32'h0);
    rd(puel_pkg::SUPPRESS_OFF, 32'h0);
    rd(12'h200, 32'h0);
    $display("header and reset values done");
    cfg_be = 4'h4;
    wr(puel_pkg::SUPPRESS_OFF, 32'hffff_ffff);
    rd(puel_pkg::SUPPRESS_OFF, 32'h001f_0000);
    cfg_be = 4'hf;
    wr(puel_pkg::SUPPRESS_OFF, 32'hffff_ffff);
    mask_m = IMPL;
    rd(puel_pkg::SUPPRESS_OFF, IMPL);
    step(32'hffff_ffff, 32'h0);
    rd(puel_pkg::FLAGS_OFF, 32'h0);
    wr(puel_pkg::SUPPRESS_OFF, 32'h0);
    mask_m = 32'h0;
    $display("mask done");
    foreach (bits[k]) begin
      step(32'h1 << bits[k], 32'h0);
      rd(puel_pkg::FLAGS_OFF, flags_m);
      wr(puel_pkg::FLAGS_OFF, 32'h0);
      rd(puel_pkg::FLAGS_OFF, flags_m);
      step(32'h0, 32'h1 << bits[k]);
    end
    step(32'h0004_0000, 32'h0004_0000);
    rd(puel_pkg::FLAGS_OFF, 32'h0004_0000);
    $display("single events done");
    repeat (40) begin
      r = xs();
      if (r[0]) wr(puel_pkg::SUPPRESS_OFF, r);
      if (r[0]) mask_m = r & IMPL;
      step(xs(), xs() & xs());
      rd(puel_pkg::FLAGS_OFF, flags_m);
    end
    $display("random events done");
    pin_reset(1'h0);
    pin_reset(1'h1);
    $display("pin resets done");
    chk(exp_q.size(), 32'h0, "answers missing");
    end_sim();
  end
endmodule : puel_top_tb
